// ---- hw/amot_defs.svh ----
// register offsets, field positions, reset values of the alarm/offset trim bank
`ifndef AMOT_DEFS_SVH
`define AMOT_DEFS_SVH

`define AMOT_ADDR_W 12
`define AMOT_DATA_W 16
`define AMOT_LANES 8
`define AMOT_TRIM_W 12
`define AMOT_ALM_W 6

`define AMOT_OFS_SUMMARY 12'h2c0
`define AMOT_OFS_STATUS 12'h2c1
`define AMOT_OFS_MASK 12'h2c2
`define AMOT_OFS_CALSTAT 12'h2c3
`define AMOT_OFS_LANE 12'h2c4
`define AMOT_OFS_TRIM0 12'h330
`define AMOT_OFS_TRIM1 12'h332
`define AMOT_OFS_TRIM2A 12'h334
`define AMOT_OFS_TRIM2B 12'h336

`define AMOT_BIT_FIFO 5
`define AMOT_BIT_PLL 4
`define AMOT_BIT_LINK 3
`define AMOT_BIT_REALIGN 2
`define AMOT_BIT_RSVD 1
`define AMOT_BIT_CLK 0

`define AMOT_RST_STATUS 6'h3f
`define AMOT_RST_MASK 6'h3f
`define AMOT_RST_LANE 8'hff
`define AMOT_RST_TRIM 12'h000
`define AMOT_MASK_RSVD_READ 6'h02
`define AMOT_MASK_LIVE 6'h3d

`endif

// ---- hw/amot_pkg.sv ----
// types shared by the alarm/offset trim register bank
package amot_pkg;
	typedef logic [11:0] amot_addr_t;
	typedef logic [15:0] amot_data_t;
	typedef logic [11:0] amot_trim_t;
	typedef logic [7:0] amot_lanes_t;
	typedef logic [5:0] amot_alm_t;
	typedef enum logic [3:0] {
		AMOT_SEL_NONE,
		AMOT_SEL_SUMMARY,
		AMOT_SEL_STATUS,
		AMOT_SEL_MASK,
		AMOT_SEL_CALSTAT,
		AMOT_SEL_LANE,
		AMOT_SEL_TRIM0,
		AMOT_SEL_TRIM1,
		AMOT_SEL_TRIM2A,
		AMOT_SEL_TRIM2B
	} amot_sel_t;
endpackage

// ---- hw/amot_lane_if.sv ----
// carrier between the register decode and the per-lane alarm flags
`timescale 1ns/10ps
interface amot_lane_if;
	logic [7:0] clear_bits;
	logic [7:0] lane_err;
	logic [7:0] flags;
	modport ctrl (output clear_bits, output lane_err, input flags);
	modport lanes (input clear_bits, input lane_err, output flags);
endinterface

// ---- hw/amot_lane_alarm.sv ----
// per-lane sticky fifo overflow/underflow flags, write-one-to-clear
`timescale 1ns/10ps
`include "amot_defs.svh"
module amot_lane_alarm (
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset, high
	amot_lane_if.lanes lif // clear requests in, flags out
);
	import amot_pkg::*;

	amot_lanes_t flags_reg;
	amot_lanes_t flags_next;

	genvar i;
	generate
		for (i = 0; i < `AMOT_LANES; i++)
		begin : g_lane
			// a lane still in error sets again over the clear
			always_comb
			begin
				flags_next[i] = (flags_reg[i] & ~lif.clear_bits[i]) | lif.lane_err[i];
			end
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (rst)
			flags_reg <= `AMOT_RST_LANE;
		else
			flags_reg <= flags_next;
	end

	assign lif.flags = flags_reg;
endmodule

// ---- hw/amot_regs.sv ----
// alarm mask, lane fifo alarm and offset trim register bank
//
// Implementation choice: the strobed register port.
`timescale 1ns/10ps
`include "amot_defs.svh"

// Functional notes
// - mask bit 5 set keeps lane fifo alarm out of summary alarm.
// - mask bit 4 set keeps serializer pll lock-lost alarm out of summary.
// - mask bit 3 set keeps link alarm out of summary alarm.
// - mask bit 2 set keeps clock realignment alarm out of summary.
// - mask bit 0 set keeps divider mismatch alarm out of summary.
// - lane i fifo overflow or underflow sets lane alarm flag bit i.
// - writing one clears a lane alarm flag; zero leaves it alone.
// - a cleared lane flag sets again while its fault persists.
// - writing one to summary fifo status bit clears all lane flags.
// - lane alarm flags reset to all ones.
// - core 0 trim bits 11:0 drive core 0 offset correction.
// - core 1 trim bits 11:0 drive core 1 offset correction.
// - core 2 input a trim applies only while core 2 samples input a.
// - summary alarm reads one when any unmasked status bit is set.
// - fifo status bit sets on active lane fault, clears by writing one.
module amot_regs (
	input wire logic clk, // 25 MHz system clock
	input wire logic rst, // synchronous reset, high
	input wire amot_pkg::amot_addr_t addr, // register address
	input wire amot_pkg::amot_data_t wdata, // write data
	input wire logic wr_en, // write strobe
	input wire logic rd_en, // read strobe
	output amot_pkg::amot_data_t rdata, // read data, cycle after rd_en
	input wire amot_pkg::amot_lanes_t lane_fifo_err, // per-lane over/underflow
	input wire amot_pkg::amot_lanes_t lane_active, // lanes in use
	input wire logic serializer_pll_alarm, // pll not locked
	input wire logic link_state_alarm, // link not in data state
	input wire logic realign_alarm, // clocks realigned
	input wire logic divider_mismatch_alarm, // clock dividers disagree
	input wire logic core2_input_b_sel, // core 2 samples input b
	input wire logic offset_cal_enable, // offset calibration enabled
	input wire logic background_cal_enable, // background calibration on
	input wire logic background_offset_cal_enable, // background offset cal on
	input wire logic foreground_cal_done, // foreground calibration done
	output logic summary_alarm, // any unmasked alarm
	output amot_pkg::amot_trim_t core0_offset, // core 0 correction
	output amot_pkg::amot_trim_t core1_offset, // core 1 correction
	output amot_pkg::amot_trim_t core2_offset, // core 2 correction, by input
	output logic trim_access_ok // trims safe to touch now
);
	import amot_pkg::*;

	amot_sel_t sel;
	logic wr_status;
	logic wr_lane;
	logic wr_mask;

	amot_alm_t status_reg;
	amot_alm_t status_next;
	amot_alm_t alarm_events;
	amot_alm_t mask_reg;
	amot_alm_t mask_next;
	logic summary_reg;
	logic summary_next;

	amot_trim_t trim0_reg;
	amot_trim_t trim0_next;
	amot_trim_t trim1_reg;
	amot_trim_t trim1_next;
	amot_trim_t trim2a_reg;
	amot_trim_t trim2a_next;
	amot_trim_t trim2b_reg;
	amot_trim_t trim2b_next;
	amot_trim_t core2_reg;
	amot_trim_t core2_next;

	logic access_ok_reg;
	logic access_ok_next;
	amot_data_t rdata_reg;
	amot_data_t rdata_next;

	amot_lane_if lif ();

	amot_lane_alarm u_lane_alarm (
		.clk(clk),
		.rst(rst),
		.lif(lif)
	);

	// address decode
	always_comb
	begin
		case (addr)
			`AMOT_OFS_SUMMARY: sel = AMOT_SEL_SUMMARY;
			`AMOT_OFS_STATUS: sel = AMOT_SEL_STATUS;
			`AMOT_OFS_MASK: sel = AMOT_SEL_MASK;
			`AMOT_OFS_CALSTAT: sel = AMOT_SEL_CALSTAT;
			`AMOT_OFS_LANE: sel = AMOT_SEL_LANE;
			`AMOT_OFS_TRIM0: sel = AMOT_SEL_TRIM0;
			`AMOT_OFS_TRIM1: sel = AMOT_SEL_TRIM1;
			`AMOT_OFS_TRIM2A: sel = AMOT_SEL_TRIM2A;
			`AMOT_OFS_TRIM2B: sel = AMOT_SEL_TRIM2B;
			default: sel = AMOT_SEL_NONE;
		endcase
	end

	assign wr_status = wr_en && (sel == AMOT_SEL_STATUS);
	assign wr_lane = wr_en && (sel == AMOT_SEL_LANE);
	assign wr_mask = wr_en && (sel == AMOT_SEL_MASK);

	// lane flag clears: direct write or via the summary fifo status bit
	always_comb
	begin
		lif.clear_bits = '0;
		if (wr_lane)
			lif.clear_bits = wdata[7:0];
		if (wr_status && wdata[`AMOT_BIT_FIFO])
			lif.clear_bits = `AMOT_RST_LANE;
		lif.lane_err = lane_fifo_err;
	end

	// alarm status: hardware set wins over a same-cycle software clear
	always_comb
	begin
		alarm_events = '0;
		alarm_events[`AMOT_BIT_FIFO] = |(lane_fifo_err & lane_active);
		alarm_events[`AMOT_BIT_PLL] = serializer_pll_alarm;
		alarm_events[`AMOT_BIT_LINK] = link_state_alarm;
		alarm_events[`AMOT_BIT_REALIGN] = realign_alarm;
		alarm_events[`AMOT_BIT_CLK] = divider_mismatch_alarm;
		status_next = status_reg;
		if (wr_status)
			status_next = status_reg & ~wdata[5:0];
		status_next = status_next | alarm_events;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			status_reg <= `AMOT_RST_STATUS;
		else
			status_reg <= status_next;
	end

	// mask keeps only live bits; the reserved bit 1 is forced to one on readback
	always_comb
	begin
		mask_next = mask_reg;
		if (wr_mask)
			mask_next = wdata[5:0] & `AMOT_MASK_LIVE;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			mask_reg <= `AMOT_RST_MASK & `AMOT_MASK_LIVE;
		else
			mask_reg <= mask_next;
	end

	// summary from the registered status; the reserved status bit never counts
	always_comb
	begin
		summary_next = 1'b0;
		if (status_reg[`AMOT_BIT_FIFO] && !mask_reg[`AMOT_BIT_FIFO])
			summary_next = 1'b1;
		if (status_reg[`AMOT_BIT_PLL] && !mask_reg[`AMOT_BIT_PLL])
			summary_next = 1'b1;
		if (status_reg[`AMOT_BIT_LINK] && !mask_reg[`AMOT_BIT_LINK])
			summary_next = 1'b1;
		if (status_reg[`AMOT_BIT_REALIGN] && !mask_reg[`AMOT_BIT_REALIGN])
			summary_next = 1'b1;
		if (status_reg[`AMOT_BIT_CLK] && !mask_reg[`AMOT_BIT_CLK])
			summary_next = 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			summary_reg <= 1'b0;
		else
			summary_reg <= summary_next;
	end

	// offset trims; upper reserved nibble is not stored
	always_comb
	begin
		trim0_next = trim0_reg;
		trim1_next = trim1_reg;
		trim2a_next = trim2a_reg;
		trim2b_next = trim2b_reg;
		if (wr_en)
		begin
			case (sel)
				AMOT_SEL_TRIM0: trim0_next = wdata[11:0];
				AMOT_SEL_TRIM1: trim1_next = wdata[11:0];
				AMOT_SEL_TRIM2A: trim2a_next = wdata[11:0];
				AMOT_SEL_TRIM2B: trim2b_next = wdata[11:0];
				default: trim0_next = trim0_reg;
			endcase
		end
		core2_next = core2_input_b_sel ? trim2b_reg : trim2a_reg;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			trim0_reg <= `AMOT_RST_TRIM;
			trim1_reg <= `AMOT_RST_TRIM;
			trim2a_reg <= `AMOT_RST_TRIM;
			trim2b_reg <= `AMOT_RST_TRIM;
			core2_reg <= `AMOT_RST_TRIM;
		end
		else
		begin
			trim0_reg <= trim0_next;
			trim1_reg <= trim1_next;
			trim2a_reg <= trim2a_next;
			trim2b_reg <= trim2b_next;
			core2_reg <= core2_next;
		end
	end

	// advisory only: the bank never blocks a trim access, software must heed this
	always_comb
	begin
		access_ok_next = 1'b1;
		if (background_cal_enable && background_offset_cal_enable)
			access_ok_next = 1'b0;
		else if (offset_cal_enable)
			access_ok_next = foreground_cal_done;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			access_ok_reg <= 1'b0;
		else
			access_ok_reg <= access_ok_next;
	end

	// read data stand only in the cycle after the strobe
	always_comb
	begin
		rdata_next = '0;
		if (rd_en)
		begin
			case (sel)
				AMOT_SEL_SUMMARY: rdata_next[0] = summary_reg;
				AMOT_SEL_STATUS: rdata_next[5:0] = status_reg;
				AMOT_SEL_MASK: rdata_next[5:0] = mask_reg | `AMOT_MASK_RSVD_READ;
				AMOT_SEL_CALSTAT: rdata_next[0] = access_ok_reg;
				AMOT_SEL_LANE: rdata_next[7:0] = lif.flags;
				AMOT_SEL_TRIM0: rdata_next[11:0] = trim0_reg;
				AMOT_SEL_TRIM1: rdata_next[11:0] = trim1_reg;
				AMOT_SEL_TRIM2A: rdata_next[11:0] = trim2a_reg;
				AMOT_SEL_TRIM2B: rdata_next[11:0] = trim2b_reg;
				default: rdata_next = '0;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			rdata_reg <= '0;
		else
			rdata_reg <= rdata_next;
	end

	assign rdata = rdata_reg;
	assign summary_alarm = summary_reg;
	assign core0_offset = trim0_reg;
	assign core1_offset = trim1_reg;
	assign core2_offset = core2_reg;
	assign trim_access_ok = access_ok_reg;
endmodule

// ---- sim/amot_regs_assertions.sv ----
// checker watching the trim bank ports
`timescale 1ns/10ps
module amot_regs_checker (
	input wire logic clk, // clock
	input wire logic rst, // reset
	input wire amot_pkg::amot_addr_t addr, // address
	input wire amot_pkg::amot_data_t wdata, // write data
	input wire logic wr_en, // write strobe
	input wire logic rd_en, // read strobe
	input wire amot_pkg::amot_data_t rdata, // read data
	input wire amot_pkg::amot_lanes_t lane_fifo_err, // lane faults
	input wire amot_pkg::amot_lanes_t lane_active, // lanes in use
	input wire logic core2_input_b_sel, // core 2 input
	input wire logic offset_cal_enable, // offset cal
	input wire logic background_cal_enable, // bg cal
	input wire logic background_offset_cal_enable, // bg offset cal
	input wire logic foreground_cal_done, // foreground_cal_done
	input wire logic summary_alarm, // summary
	input wire amot_pkg::amot_trim_t core0_offset, // core 0
	input wire amot_pkg::amot_trim_t core1_offset, // core 1
	input wire amot_pkg::amot_trim_t core2_offset, // core 2
	input wire logic trim_access_ok // advisory
);
	import amot_pkg::*;
	logic [5:0] mask_sh;
	logic bg_both;
	assign bg_both = background_cal_enable && background_offset_cal_enable;
	// shadow of the mask so summary checks know which sources count
	always_ff @(posedge clk)
	begin
		if (rst)
			mask_sh <= 6'h3f;
		else if (wr_en && addr == 12'h2c2)
			mask_sh <= wdata[5:0];
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	rdata_idle_a: assert property (!rd_en |=> rdata == 16'h0000)
		else $error("read data not zero outside read slot");
	trim0_apply_a: assert property (wr_en && addr == 12'h330 |=> core0_offset == $past(wdata[11:0]))
		else $error("core 0 offset not the written trim");
	trim1_apply_a: assert property (wr_en && addr == 12'h332 |=> core1_offset == $past(wdata[11:0]))
		else $error("core 1 offset not the written trim");
	core2_in_a_a: assert property (wr_en && addr == 12'h334 ##1 !core2_input_b_sel
		|=> core2_offset == $past(wdata[11:0], 2))
		else $error("core 2 offset not input a trim");
	core2_in_b_a: assert property (wr_en && addr == 12'h336 ##1 core2_input_b_sel
		|=> core2_offset == $past(wdata[11:0], 2))
		else $error("core 2 offset not input b trim");
	bg_block_a: assert property (bg_both |=> !trim_access_ok)
		else $error("trim access allowed under background offset cal");
	fg_wait_a: assert property (offset_cal_enable && !bg_both
		|=> trim_access_ok == $past(foreground_cal_done))
		else $error("trim access not following foreground done");
	free_access_a: assert property (!offset_cal_enable && !bg_both |=> trim_access_ok)
		else $error("trim access refused with no calibration");
	fifo_summary_a: assert property ((|(lane_fifo_err & lane_active)) && !mask_sh[5]
		##1 !mask_sh[5] |=> summary_alarm)
		else $error("unmasked lane fault missing from summary");
	cover property (wr_en && addr == 12'h336 ##1 core2_input_b_sel);
	cover property (rd_en ##1 rdata != 16'h0000);
	cover property (summary_alarm);
endmodule
bind amot_regs amot_regs_checker chk (.*);

// ---- sim/tb_alarm_mask_offset_trim_regs.sv ----
// self-checking bench for the alarm mask, lane alarm and trim bank
`timescale 1ns/10ps
module tb_alarm_mask_offset_trim_regs;
	import amot_pkg::*;
	logic clk = 0;
	logic rst = 1;
	amot_addr_t addr = 12'h000;
	amot_data_t wdata = 16'h0000;
	logic wr_en = 0;
	logic rd_en = 0;
	logic rd_d = 0;
	amot_lanes_t lerr = 8'h00;
	amot_lanes_t r;
	logic [5:0] src = 6'h00;
	logic bsel = 0;
	amot_lanes_t act = 8'hff;
	logic sa;
	logic ta;
	logic e;
	logic [3:0] cal = 4'h0;
	amot_data_t rdata;
	amot_trim_t c0, c1, c2;
	amot_trim_t v[4];
	amot_data_t exp_q[$];
	int bit_of[5] = '{5, 4, 3, 2, 0};
	int n_mismatch = 0;
	int total_checks = 0;
	always #20 clk = ~clk;
	amot_regs uut (
		.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
		.rdata(rdata), .lane_fifo_err(lerr | {7'h00, src[5]}), .lane_active(act),
		.serializer_pll_alarm(src[4]), .link_state_alarm(src[3]), .realign_alarm(src[2]),
		.divider_mismatch_alarm(src[0]), .core2_input_b_sel(bsel),
		.offset_cal_enable(cal[3]), .background_cal_enable(cal[2]),
		.background_offset_cal_enable(cal[1]), .foreground_cal_done(cal[0]),
		.summary_alarm(sa), .core0_offset(c0), .core1_offset(c1), .core2_offset(c2),
		.trim_access_ok(ta)
	);
	task chk(input string nm, input amot_data_t got, input amot_data_t ex);
		total_checks++;
		if (got !== ex)
		begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", nm, ex, got);
		end
	endtask
	// strobe dropped a cycle before the next request, never re-raised in one step
	task wr(input amot_addr_t a, input amot_data_t d);
		addr <= a;
		wdata <= d;
		wr_en <= 1;
		@(posedge clk);
		wr_en <= 0;
		@(posedge clk);
	endtask
	task rd(input amot_addr_t a, input amot_data_t ex);
		exp_q.push_back(ex);
		addr <= a;
		rd_en <= 1;
		@(posedge clk);
		rd_en <= 0;
		@(posedge clk);
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task results;
		if (n_mismatch == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// read data is only valid in the cycle after the strobe
	always @(posedge clk)
	begin
		rd_d <= rd_en && !rst;
		if (rd_d)
			chk("rdata", rdata, exp_q.pop_front());
	end
	initial
	begin
		void'($urandom(32'hff04));
		tick(6);
		rst <= 0;
		rd(12'h2c4, 16'h00ff);
		rd(12'h2c2, 16'h003f);
		rd(12'h330, 16'h0000);
		for (int j = 0; j < 4; j++)
		begin
			v[j] = amot_trim_t'($urandom);
			bsel <= j[0];
			wr(12'h330 + 12'(2 * j), {4'h0, v[j]});
		end
		for (int j = 0; j < 4; j++)
			rd(12'h330 + 12'(2 * j), {4'h0, v[j]});
		chk("core0", {4'h0, c0}, {4'h0, v[0]});
		chk("core1", {4'h0, c1}, {4'h0, v[1]});
		chk("core2", {4'h0, c2}, {4'h0, v[3]});
		bsel <= 0;
		tick(2);
		chk("core2", {4'h0, c2}, {4'h0, v[2]});
		wr(12'h100, 16'hffff);
		rd(12'h100, 16'h0000);
		wr(12'h2c4, 16'h0001);
		rd(12'h2c4, 16'h00fe);
		lerr <= 8'h08;
		wr(12'h2c4, 16'h00ff);
		rd(12'h2c4, 16'h0008);
		lerr <= 8'h00;
		wr(12'h2c4, 16'h0008);
		rd(12'h2c4, 16'h0000);
		r = amot_lanes_t'($urandom);
		lerr <= r;
		tick(1);
		lerr <= 8'h00;
		rd(12'h2c4, {8'h00, r});
		wr(12'h2c1, 16'h0020);
		rd(12'h2c4, 16'h0000);
		wr(12'h2c1, 16'h003f);
		act <= 8'hfe;
		lerr <= 8'h01;
		tick(1);
		lerr <= 8'h00;
		act <= 8'hff;
		rd(12'h2c1, 16'h0000);
		lerr <= 8'h02;
		tick(1);
		lerr <= 8'h00;
		rd(12'h2c1, 16'h0020);
		for (int k = 0; k < 10; k++)
		begin
			wr(12'h2c2, k[0] ? 16'h003f : 16'(16'h003f & ~(32'h1 << bit_of[k / 2])));
			wr(12'h2c1, 16'h003f);
			src <= 6'(32'h1 << bit_of[k / 2]);
			tick(1);
			src <= 6'h00;
			tick(2);
			rd(12'h2c0, {15'h0000, !k[0]});
			chk("summary_alarm", {15'h0000, sa}, {15'h0000, !k[0]});
		end
		for (int i = 0; i < 16; i++)
		begin
			cal <= i[3:0];
			e = (i[2] && i[1]) ? 1'b0 : (i[3] ? i[0] : 1'b1);
			tick(1);
			rd(12'h2c3, {15'h0000, e});
			chk("trim_access_ok", {15'h0000, ta}, {15'h0000, e});
		end
		results();
	end
	initial
	begin
		tick(5000);
		n_mismatch++;
		results();
	end
endmodule
